// ==== cbw_pkg.sv ====
// Purpose: shared constants for the core bus pin-control block and its memory end
// Assumes: single 40 MHz clock, all pin timing modelled at whole-cycle granularity
// Notes: address in byte units, instructions are one word long
package cbw_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NARROW_W = 26;
    localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
    localparam logic [31:0] SEQ_STEP = 32'h0000_0004;
    localparam logic [31:0] NARROW_MASK = 32'h03ff_ffff;
    localparam int CLK_PERIOD_NS = 25;
    // memory end: wait cycles inserted on a slow region access
    localparam int SLOW_WAIT_CYCLES = 2;
    localparam logic [3:0] SLOW_WAIT_CNT = 4'h2;
    // address bit 20 marks a slow region for the memory end
    localparam int SLOW_BIT = 20;
    // least cycles the memory end holds the core in reset
    localparam logic [3:0] RESET_HOLD_CNT = 4'h2;
    // access kinds issued by the core end
    typedef enum logic [1:0] {
        CBW_IDLE = 2'b00,
        CBW_FETCH = 2'b01,
        CBW_LOAD = 2'b11,
        CBW_STORE = 2'b10
    } cbw_kind_type;
endpackage : cbw_pkg

// ==== cbw_bus_if.sv ====
// Purpose: pin bundle between the core end and the memory end
// Assumes: output enables low while a pin is driven
// Notes: resolves the shared data wire from the enables
`timescale 1ns/1ps
interface cbw_bus_if;
    logic [31:0] addr_o;
    logic [31:0] addr_oe_n;
    logic [31:0] core_data_o;
    logic core_data_oe_n;
    logic [31:0] mem_data_o;
    logic mem_data_oe_n;
    logic [31:0] data_wire;
    logic write_not_read;
    logic byte_not_word_n;
    logic translate_n;
    logic opcode_fetch_n;
    logic lock;
    logic ctrl_oe_n;
    logic mem_request_n;
    logic sequential_addr_hint;
    logic stall_request_n;
    logic cpu_reset_n;
    logic test_reset_n;
    logic test_bus_float_n;
    logic addr_bus_drive_en;
    logic data_bus_drive_en;
    logic program_width_sel;
    // the memory end returns read data only while the core is not driving
    assign data_wire = !core_data_oe_n ? core_data_o : (!mem_data_oe_n ? mem_data_o : '0);
    modport core (
        output addr_o, addr_oe_n, core_data_o, core_data_oe_n, write_not_read,
        output byte_not_word_n, translate_n, opcode_fetch_n, lock, ctrl_oe_n,
        output mem_request_n, sequential_addr_hint,
        input data_wire, stall_request_n, cpu_reset_n, test_reset_n, test_bus_float_n,
        input addr_bus_drive_en, data_bus_drive_en, program_width_sel
    );
    modport mem (
        output mem_data_o, mem_data_oe_n, stall_request_n, cpu_reset_n, test_reset_n,
        output test_bus_float_n, addr_bus_drive_en, data_bus_drive_en, program_width_sel,
        input addr_o, addr_oe_n, data_wire, write_not_read, byte_not_word_n, translate_n,
        input opcode_fetch_n, lock, ctrl_oe_n, mem_request_n, sequential_addr_hint
    );
endinterface : cbw_bus_if

// ==== cbw_pin_sync.sv ====
// Purpose: three-stage synchroniser for one pin level
// Assumes: input is asynchronous to core_clk_i
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module cbw_pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // pin and result
    input wire logic pin_i,
    output logic level_o
);
    logic [2:0] stage_reg;
    logic level_reg;
    wire agree = (stage_reg[1] == stage_reg[2]);
    // first stage feeds only the second; agreement filters a one-cycle glitch
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_reg <= {3{RESET_VAL}};
            level_reg <= RESET_VAL;
        end else begin
            stage_reg <= {stage_reg[1:0], pin_i};
            if (agree) begin
                level_reg <= stage_reg[2];
            end
        end
    end
    assign level_o = level_reg;
endmodule : cbw_pin_sync

// ==== cbw_core_end.sv ====
// Purpose: bus pin control of the processor end: wait, address width, sequential hint, floats
// Assumes: memory end keeps its own obligations on the pins it drives
// Notes: the instruction stream is a simple model driven from user-side request ports
`timescale 1ns/1ps
module cbw_core_end (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // pin side
    cbw_bus_if.core bus,
    // user side: next access request
    input wire logic req_valid_i,
    input wire logic [1:0] req_kind_i,
    input wire logic req_byte_i,
    input wire logic req_jump_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [31:0] req_wdata_i,
    input wire logic req_user_i,
    input wire logic req_lock_i,
    // user side: status
    output logic req_ready_o,
    output logic rdata_valid_o,
    output logic [31:0] rdata_o,
    output logic [31:0] fetch_addr_o,
    output logic scan_state_o
);
    typedef enum logic [1:0] {
        CBW_RESET = 2'b00,
        CBW_RUN = 2'b01,
        CBW_STALL = 2'b11
    } cbw_state_type;
    cbw_state_type state_reg, state_next;
    logic wait_n_s, creset_n_s, treset_n_s, tbe_s, abe_s, dbe_s, wide_s;
    logic [31:0] addr_reg, addr_next, pc_reg, pc_next, wdata_reg;
    logic [1:0] kind_reg;
    logic byte_reg, user_reg, lock_reg, seq_reg, seq_next, mreq_n_reg;
    logic rvalid_reg, rpend_reg, scan_reg;
    logic [31:0] rdata_reg;
    // every control pin level from the memory end crosses through a three-stage filter; read data does not
    logic [6:0] pin_raw, pin_s;
    // both reset pins sit low while reset_n_i is low, so their filters start low:
    // starting them high would fake a release, and a burst of running, right after reset
    localparam logic [6:0] PIN_RESET = 7'h4f;
    assign pin_raw = {bus.stall_request_n, bus.cpu_reset_n, bus.test_reset_n,
        bus.test_bus_float_n, bus.addr_bus_drive_en, bus.data_bus_drive_en,
        bus.program_width_sel};
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sync
            cbw_pin_sync #(.RESET_VAL(PIN_RESET[gi])) u_sync (
                .core_clk_i(core_clk_i),
                .reset_n_i(reset_n_i),
                .pin_i(pin_raw[gi]),
                .level_o(pin_s[gi])
            );
        end
    endgenerate
    assign {wait_n_s, creset_n_s, treset_n_s, tbe_s, abe_s, dbe_s, wide_s} = pin_s;
    // the wait pin is sampled at cycle level here, which makes clock-low changes moot
    wire stalled = !wait_n_s;
    // narrow configuration masks the fetch address down to 26 bits
    wire [31:0] fetch_mask = wide_s ? '1 : cbw_pkg::NARROW_MASK;
    wire is_fetch = (req_kind_i == cbw_pkg::CBW_FETCH);
    wire [31:0] sel_addr = req_jump_i ? req_addr_i : pc_reg;
    wire [31:0] req_addr = is_fetch ? (sel_addr & fetch_mask) : req_addr_i;
    // related address: a non-jump fetch continues at pc, same or plus four
    wire next_related = req_valid_i && is_fetch && !req_jump_i;
    wire issue = (state_reg == CBW_RUN) && req_valid_i && !stalled;
    assign pc_next = issue && is_fetch ? ((req_addr + cbw_pkg::SEQ_STEP) & fetch_mask) : pc_reg;
    // state sequencing: reset, run, stall
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        seq_next = seq_reg;
        unique case (state_reg)
            CBW_RESET: begin
                addr_next = cbw_pkg::RESET_ADDR;
                seq_next = 1'b0;
                if (creset_n_s) begin
                    state_next = CBW_RUN;
                end
            end
            CBW_RUN: begin
                if (stalled) begin
                    state_next = CBW_STALL;
                end else if (req_valid_i) begin
                    addr_next = req_addr;
                    seq_next = next_related; // hint registered in the same cycle as its access address
                end
            end
            CBW_STALL: begin
                if (!stalled) begin
                    state_next = CBW_RUN;
                end
            end
        endcase
        if (!creset_n_s) begin
            state_next = CBW_RESET;
        end
    end
    // bus request registers hold while stalled
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= CBW_RESET;
            addr_reg <= cbw_pkg::RESET_ADDR;
            pc_reg <= cbw_pkg::RESET_ADDR;
            seq_reg <= 1'b0;
            mreq_n_reg <= 1'b1;
            kind_reg <= cbw_pkg::CBW_IDLE;
            byte_reg <= 1'b0;
            user_reg <= 1'b0;
            lock_reg <= 1'b0;
            wdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            seq_reg <= seq_next;
            pc_reg <= (state_reg == CBW_RESET) ? cbw_pkg::RESET_ADDR : pc_next;
            if (issue) begin
                mreq_n_reg <= 1'b0;
                kind_reg <= req_kind_i;
                byte_reg <= req_byte_i;
                user_reg <= req_user_i;
                lock_reg <= req_lock_i;
                wdata_reg <= req_wdata_i;
            end else if (!stalled) begin
                mreq_n_reg <= 1'b1;
                kind_reg <= cbw_pkg::CBW_IDLE;
            end
        end
    end
    // the memory end answers in the cycle after the address, so read data is taken one
    // cycle after a non-stalled load or fetch; a store issued in that cycle would collide
    wire read_done = !mreq_n_reg && !stalled && (kind_reg != cbw_pkg::CBW_STORE);
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rpend_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            rpend_reg <= read_done;
            rvalid_reg <= rpend_reg;
            if (rpend_reg) begin
                rdata_reg <= bus.data_wire;
            end
        end
    end
    // scan state follows the test reset and is cleared by reset_n_i, never by the core reset
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan_reg <= 1'b0;
        end else begin
            scan_reg <= treset_n_s;
        end
    end
    // test float has no scan path: it gates the enables directly
    wire addr_float = !tbe_s || !abe_s;
    wire data_float = !tbe_s || !dbe_s;
    wire drive_wdata = (kind_reg == cbw_pkg::CBW_STORE) && !mreq_n_reg;
    assign bus.addr_o = addr_reg;
    assign bus.addr_oe_n = {32{addr_float}};
    assign bus.ctrl_oe_n = addr_float;
    assign bus.core_data_o = wdata_reg;
    assign bus.core_data_oe_n = data_float || !drive_wdata;
    assign bus.write_not_read = (kind_reg == cbw_pkg::CBW_STORE);
    assign bus.byte_not_word_n = !byte_reg;
    assign bus.translate_n = !user_reg;
    assign bus.opcode_fetch_n = (kind_reg != cbw_pkg::CBW_FETCH);
    assign bus.lock = lock_reg;
    assign bus.mem_request_n = mreq_n_reg;
    assign bus.sequential_addr_hint = seq_reg;
    assign req_ready_o = (state_reg == CBW_RUN) && !stalled;
    assign rdata_valid_o = rvalid_reg;
    assign rdata_o = rdata_reg;
    assign fetch_addr_o = pc_reg;
    assign scan_state_o = scan_reg;
    // are kept by the memory end
endmodule : cbw_core_end

// ==== cbw_mem_end.sv ====
// Purpose: memory controller end: drives wait, resets, configuration and bus enables
// Assumes: core end outputs arrive on the same clock, so no synchroniser here
// Notes: read data is a simple pattern of the address; slow region gets wait cycles
`timescale 1ns/1ps
module cbw_mem_end (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // pin side
    cbw_bus_if.mem bus,
    // user side: configuration
    input wire logic wide_mode_i,
    input wire logic core_in_narrow_mode_i,
    input wire logic test_float_i,
    input wire logic addr_bus_off_i,
    input wire logic data_bus_off_i,
    // user side: observation
    output logic [31:0] last_write_o,
    output logic width_applied_o
);
    logic [3:0] reset_cnt_reg, wait_cnt_reg;
    logic creset_n_reg, treset_n_reg, wait_n_reg, width_reg, tbe_reg;
    logic abe_reg, dbe_reg, mdata_oe_n_reg;
    logic [31:0] mdata_reg, last_write_reg;
    wire access = !bus.mem_request_n;
    wire slow = bus.addr_o[cbw_pkg::SLOW_BIT];
    // hold core reset low at least two cycles with wait high, pulse test reset too
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reset_cnt_reg <= '0;
            creset_n_reg <= 1'b0;
            treset_n_reg <= 1'b0;
        end else begin
            if (reset_cnt_reg != cbw_pkg::RESET_HOLD_CNT) begin
                reset_cnt_reg <= reset_cnt_reg + 4'h1;
            end
            creset_n_reg <= (reset_cnt_reg == cbw_pkg::RESET_HOLD_CNT);
            treset_n_reg <= (reset_cnt_reg == cbw_pkg::RESET_HOLD_CNT);
        end
    end
    // wait cycles for slow accesses; otherwise wait stays high
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_cnt_reg <= '0;
            wait_n_reg <= 1'b1;
        end else if (!creset_n_reg) begin
            wait_cnt_reg <= '0;
            wait_n_reg <= 1'b1;
        end else if (wait_cnt_reg != 4'h0) begin
            wait_cnt_reg <= wait_cnt_reg - 4'h1;
            wait_n_reg <= (wait_cnt_reg == 4'h1);
        end else if (access && slow && wait_n_reg) begin
            wait_cnt_reg <= cbw_pkg::SLOW_WAIT_CNT;
            wait_n_reg <= 1'b0;
        end
    end
    // width changes only while the core reports narrow mode and no request is on the bus
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            width_reg <= 1'b1;
            tbe_reg <= 1'b1;
            abe_reg <= 1'b1;
            dbe_reg <= 1'b1;
        end else begin
            if (core_in_narrow_mode_i && bus.mem_request_n) begin
                width_reg <= wide_mode_i;
            end
            tbe_reg <= !test_float_i;
            abe_reg <= !addr_bus_off_i;
            dbe_reg <= !data_bus_off_i;
        end
    end
    // read data and write capture
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mdata_reg <= '0;
            mdata_oe_n_reg <= 1'b1;
            last_write_reg <= '0;
        end else begin
            mdata_reg <= bus.addr_o ^ cbw_pkg::NARROW_MASK;
            mdata_oe_n_reg <= !(access && !bus.write_not_read);
            if (access && bus.write_not_read && wait_n_reg) begin
                last_write_reg <= bus.data_wire;
            end
        end
    end
    assign bus.mem_data_o = mdata_reg;
    assign bus.mem_data_oe_n = mdata_oe_n_reg;
    assign bus.stall_request_n = wait_n_reg;
    assign bus.cpu_reset_n = creset_n_reg;
    assign bus.test_reset_n = treset_n_reg;
    assign bus.test_bus_float_n = tbe_reg;
    assign bus.addr_bus_drive_en = abe_reg;
    assign bus.data_bus_drive_en = dbe_reg;
    assign bus.program_width_sel = width_reg;
    assign last_write_o = last_write_reg;
    assign width_applied_o = width_reg;
endmodule : cbw_mem_end

// ==== cbw_bus_assertions.sv ====
// Purpose: pin-rule checks across the core end and the memory end
// Assumes: one clock; enables, wait and resets cross three-flop synchronisers
// Notes: hold windows carry slack for that synchroniser latency
`timescale 1ns/1ps
module cbw_bus_assertions (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // pins driven by the core end
    input wire logic [31:0] addr_o,
    input wire logic [31:0] addr_oe_n,
    input wire logic [31:0] core_data_o,
    input wire logic core_data_oe_n,
    input wire logic opcode_fetch_n,
    input wire logic ctrl_oe_n,
    input wire logic mem_request_n,
    input wire logic sequential_addr_hint,
    // pins driven by the memory end
    input wire logic stall_request_n,
    input wire logic cpu_reset_n,
    input wire logic test_bus_float_n,
    input wire logic addr_bus_drive_en,
    input wire logic data_bus_drive_en,
    input wire logic program_width_sel
);
    logic mreq_d_reg;
    logic [31:0] last_acc_reg;
    logic first_reg;
    logic new_acc;

    // a new access: request just began or the address moved
    assign new_acc = !mem_request_n && (mreq_d_reg || addr_o != last_acc_reg);

    // previous access address, cleared by core reset so restart compares against zero
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mreq_d_reg <= 1'b1;
            last_acc_reg <= 32'h0;
            first_reg <= 1'b1;
        end else begin
            mreq_d_reg <= mem_request_n;
            if (!cpu_reset_n) begin
                last_acc_reg <= 32'h0;
                first_reg <= 1'b1;
            end else if (!mem_request_n) begin
                last_acc_reg <= addr_o;
                first_reg <= first_reg && !new_acc;
            end
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence float_held_s;
        (!test_bus_float_n) [*7];
    endsequence
    sequence narrow_held_s;
        (!program_width_sel) [*8];
    endsequence

    a_float_addr_ctrl: assert property (float_held_s |->
        addr_oe_n == 32'hffff_ffff && ctrl_oe_n)
        else $error("address or controls driven under test float");
    a_float_data_bus: assert property (float_held_s |-> core_data_oe_n)
        else $error("data driven under test float");
    a_addr_off_ctrl: assert property ((!addr_bus_drive_en) [*7] |->
        addr_oe_n == 32'hffff_ffff && ctrl_oe_n)
        else $error("address or controls driven with address enable low");
    a_data_off_bus: assert property ((!data_bus_drive_en) [*7] |-> core_data_oe_n)
        else $error("data driven with data enable low");
    a_narrow_top_lines: assert property (narrow_held_s ##0
        (new_acc && !opcode_fetch_n) |-> addr_o[31:26] == 6'h00)
        else $error("top address lines used by a narrow fetch");
    a_hint_step_four: assert property (new_acc && sequential_addr_hint |->
        addr_o == last_acc_reg || addr_o == last_acc_reg + 32'h4)
        else $error("hinted address not same or plus four");
    a_stall_hold_out: assert property ($fell(stall_request_n) |-> ##5
        ($stable(addr_o) && $stable(core_data_o) && $stable(mem_request_n)))
        else $error("outputs moved during a stall");
    a_restart_at_zero: assert property (first_reg && cpu_reset_n && new_acc |->
        addr_o == 32'h0)
        else $error("first access after reset not at zero");
endmodule : cbw_bus_assertions

// ==== tb_top.sv ====
// Purpose: drives both ends through their user ports and checks the pins
// Assumes: the memory end answers every access; read data is address xor 03ffffff
// Notes: back-to-back accesses use distinct addresses so the monitor can tell them apart
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i;
    logic reset_n_i;
    logic req_valid_i, req_jump_i, req_byte_i, req_user_i, req_lock_i;
    logic [1:0] req_kind_i;
    logic [31:0] req_addr_i, req_wdata_i, rdata_o, last_write_o, addr_seen;
    logic req_ready_o, rdata_valid_o, mreq_seen;
    logic [31:0] fetch_addr_o;
    logic scan_state_o, width_applied_o;
    logic wide_mode_i, core_in_narrow_mode_i, test_float_i, addr_bus_off_i, data_bus_off_i;
    int bad_count = 0;
    int tests_run = 0;
    logic [32:0] exp_q[$];

    cbw_bus_if cbw_bus_if_inst ();
    cbw_core_end cbw_core_end_inst (.core_clk_i, .reset_n_i, .bus(cbw_bus_if_inst),
        .req_valid_i, .req_kind_i, .req_byte_i, .req_jump_i, .req_addr_i, .req_wdata_i,
        .req_user_i, .req_lock_i, .req_ready_o, .rdata_valid_o, .rdata_o,
        .fetch_addr_o, .scan_state_o);
    cbw_mem_end cbw_mem_end_inst (.core_clk_i, .reset_n_i, .bus(cbw_bus_if_inst),
        .wide_mode_i, .core_in_narrow_mode_i, .test_float_i, .addr_bus_off_i,
        .data_bus_off_i, .last_write_o, .width_applied_o);
    cbw_bus_assertions cbw_bus_assertions_inst (.core_clk_i, .reset_n_i,
        .addr_o(cbw_bus_if_inst.addr_o), .addr_oe_n(cbw_bus_if_inst.addr_oe_n),
        .core_data_o(cbw_bus_if_inst.core_data_o), .core_data_oe_n(cbw_bus_if_inst.core_data_oe_n),
        .opcode_fetch_n(cbw_bus_if_inst.opcode_fetch_n), .ctrl_oe_n(cbw_bus_if_inst.ctrl_oe_n),
        .mem_request_n(cbw_bus_if_inst.mem_request_n),
        .sequential_addr_hint(cbw_bus_if_inst.sequential_addr_hint),
        .stall_request_n(cbw_bus_if_inst.stall_request_n), .cpu_reset_n(cbw_bus_if_inst.cpu_reset_n),
        .test_bus_float_n(cbw_bus_if_inst.test_bus_float_n),
        .addr_bus_drive_en(cbw_bus_if_inst.addr_bus_drive_en),
        .data_bus_drive_en(cbw_bus_if_inst.data_bus_drive_en),
        .program_width_sel(cbw_bus_if_inst.program_width_sel));

    // 40 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // request held until ready is seen high; returns just after the taking edge
    task automatic issue(input logic [1:0] kind, input logic jump, input logic [31:0] addr,
                         input logic [31:0] wdata);
        int n;
        n = 0;
        req_valid_i <= 1'b1;
        req_kind_i <= kind;
        req_jump_i <= jump;
        req_addr_i <= addr;
        req_wdata_i <= wdata;
        @(negedge core_clk_i);
        while (req_ready_o !== 1'b1 && n < 200) begin
            n++;
            @(negedge core_clk_i);
        end
        check("request taken", {32'h0, req_ready_o}, 33'h1);
        @(posedge core_clk_i);
    endtask : issue

    task automatic idle(input int cycles);
        req_valid_i <= 1'b0;
        req_kind_i <= cbw_pkg::CBW_IDLE;
        repeat (cycles) @(posedge core_clk_i);
    endtask : idle

    task automatic fetch(input logic jump, input logic [31:0] addr, input logic [31:0] exp);
        exp_q.push_back({1'b0, exp});
        issue(cbw_pkg::CBW_FETCH, jump, addr, 32'h0);
    endtask : fetch

    task automatic load(input logic [31:0] addr);
        int n;
        n = 0;
        exp_q.push_back({1'b1, addr});
        issue(cbw_pkg::CBW_LOAD, 1'b0, addr, 32'h0);
        idle(1);
        while (rdata_valid_o !== 1'b1 && n < 60) begin
            n++;
            @(negedge core_clk_i);
        end
        check("read data", {1'b0, rdata_o}, {1'b0, addr ^ 32'h03ff_ffff});
        @(posedge core_clk_i);
    endtask : load

    // each new access on the pins is compared with the next expected one
    always @(negedge core_clk_i) begin
        if (cbw_bus_if_inst.mem_request_n === 1'b0 && exp_q.size() > 0 &&
            (mreq_seen !== 1'b0 || cbw_bus_if_inst.addr_o !== addr_seen)) begin
            check("access", {cbw_bus_if_inst.opcode_fetch_n, cbw_bus_if_inst.addr_o}, exp_q.pop_front());
        end
        mreq_seen = cbw_bus_if_inst.mem_request_n;
        addr_seen = cbw_bus_if_inst.addr_o;
    end

    // hang guard: the whole run needs well under 20000 cycles
    initial begin
        #500000;
        bad_count++;
        end_sim();
    end

    initial begin
        reset_n_i = 1'b0;
        {req_valid_i, req_jump_i, req_byte_i, req_user_i, req_lock_i} = 5'h00;
        req_kind_i = 2'h0;
        req_addr_i = 32'h0;
        req_wdata_i = 32'h0;
        {wide_mode_i, core_in_narrow_mode_i, test_float_i, addr_bus_off_i, data_bus_off_i} = 5'h10;
        mreq_seen = 1'b1;
        addr_seen = 32'h0;
        repeat (10) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        // back-to-back fetches from reset, then a full-width jump
        fetch(1'b0, 32'h0, 32'h0);
        fetch(1'b0, 32'h0, 32'h4);
        fetch(1'b0, 32'h0, 32'h8);
        idle(5);
        check("fetch address", {1'b0, fetch_addr_o}, 33'h0_0000_000c);
        check("scan state", {32'h0, scan_state_o}, 33'h1);
        fetch(1'b1, 32'hfc00_0020, 32'hfc00_0020);
        fetch(1'b0, 32'h0, 32'hfc00_0024);
        // width change is held back until the core is in 26-bit mode
        wide_mode_i <= 1'b0;
        idle(12);
        check("width held", {32'h0, cbw_bus_if_inst.program_width_sel}, 33'h1);
        core_in_narrow_mode_i <= 1'b1;
        idle(12);
        check("width set", {32'h0, cbw_bus_if_inst.program_width_sel}, 33'h0);
        check("width applied", {32'h0, width_applied_o}, 33'h0);
        fetch(1'b1, 32'hfc00_0010, 32'h0000_0010);
        fetch(1'b0, 32'h0, 32'h0000_0014);
        wide_mode_i <= 1'b1;
        idle(12);
        // fast and slow loads, slow store
        load(32'h0000_0100);
        load(32'h0010_0100);
        exp_q.push_back({1'b1, 32'h0010_0200});
        issue(cbw_pkg::CBW_STORE, 1'b0, 32'h0010_0200, 32'ha5a5_5a5a);
        idle(12);
        check("stored word", {1'b0, last_write_o}, {1'b0, 32'ha5a5_5a5a});
        // each float control alone
        for (int i = 0; i < 3; i++) begin
            {test_float_i, addr_bus_off_i, data_bus_off_i} <= 3'b100 >> i;
            idle(12);
            check("addr enables", {1'b0, cbw_bus_if_inst.addr_oe_n}, (i < 2) ? 33'h0_ffff_ffff : 33'h0);
            check("ctrl enable", {32'h0, cbw_bus_if_inst.ctrl_oe_n}, (i < 2) ? 33'h1 : 33'h0);
            check("data enable", {32'h0, cbw_bus_if_inst.core_data_oe_n}, 33'h1);
            // a store under each control: only the address-off case may put data on the wire
            exp_q.push_back({1'b1, 32'h0000_0300});
            issue(cbw_pkg::CBW_STORE, 1'b0, 32'h0000_0300, 32'h1234_5678);
            idle(4);
            check("floated store", {1'b0, last_write_o}, (i == 1) ? 33'h1234_5678 : 33'h0);
        end
        {test_float_i, addr_bus_off_i, data_bus_off_i} <= 3'b000;
        idle(12);
        check("addr driven", {1'b0, cbw_bus_if_inst.addr_oe_n}, 33'h0);
        // second reset in mid-run restarts at zero
        reset_n_i <= 1'b0;
        repeat (10) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        fetch(1'b0, 32'h0, 32'h0);
        idle(10);
        check("accesses left", {1'b0, 32'(exp_q.size())}, 33'h0);
        end_sim();
    end
endmodule : tb_top
